// >>> verilog/sosel_consts.vh
// constants for the status output selector: offsets, fields, codes, limits, reset values
`ifndef SOSEL_CONSTS_VH
`define SOSEL_CONSTS_VH
// register byte offsets
`define SOSEL_OFF_CTRL 12'h000
`define SOSEL_OFF_WIN 12'h004
`define SOSEL_OFF_SUBST 12'h008
`define SOSEL_OFF_SEL 12'h00C
`define SOSEL_OFF_STAT 12'h010
`define SOSEL_OFF_AIN 12'h014
`define SOSEL_OFF_FREQ 12'h018
// selector codes
`define SOSEL_CODE_DC 8'h1B
`define SOSEL_CODE_RDY 8'h32
`define SOSEL_CODE_FWD 8'h33
`define SOSEL_CODE_REV 8'h34
`define SOSEL_CODE_MAJ 8'h35
`define SOSEL_CODE_WIN 8'h36
`define SOSEL_CODE_FSRC 8'h3A
`define SOSEL_CODE_RSRC 8'h3B
`define SOSEL_CODE_MOT2 8'h3C
// source select value meaning "operator/terminal source 02"
`define SOSEL_SRC_02 2'h2
// percent limits
`define SOSEL_PCT_MAX 7'h64
`define SOSEL_HYS_MAX 7'h0A
// phase loss window, output frequency in 0.01 Hz steps
`define SOSEL_PL_FMIN 16'h01F4
`define SOSEL_PL_FMAX 16'h2710
// trip codes that count as major failure
`define SOSEL_E_MEM 8'h08
`define SOSEL_E_CUR 8'h0A
`define SOSEL_E_CPU 8'h0B
`define SOSEL_E_GND 8'h0E
`define SOSEL_E_THM 8'h13
// ctrl register fields
`define SOSEL_CTRL_FSRC_LO 0
`define SOSEL_CTRL_RSRC_LO 2
`define SOSEL_CTRL_GF_EN 4
`define SOSEL_CTRL_PL_EN 5
// reset values
`define SOSEL_RST_CTRL 32'h0000_0000
`define SOSEL_RST_WIN 32'h0000_6400
`define SOSEL_RST_SUBST 8'h80
`define SOSEL_RST_SEL 16'h0000
`endif

// >>> verilog/sosel_window.v
// window comparator with hysteresis and limit constraint
`timescale 1ns/10ps
`include "sosel_consts.vh"
module sosel_window (
  input wire pclk,
  input wire presetn,
  input wire [6:0] ain,
  input wire [6:0] upper_in,
  input wire [6:0] lower_in,
  input wire [6:0] hys_in,
  output wire [6:0] upper_eff,
  output wire [6:0] lower_eff,
  output wire [6:0] hys_eff,
  output reg hit_r
);
  wire [7:0] diff;
  wire [6:0] hys_half;
  wire [6:0] hys_lim;
  wire [6:0] hys_c;
  wire [6:0] up_c;
  wire [7:0] low_room;
  wire [6:0] low_c;
  wire [7:0] up_hi;
  wire [7:0] low_lo;
  reg hit_nxt;
  // hysteresis at most half the span and at most ten percent
  assign diff = (upper_in > lower_in) ? {1'b0, upper_in - lower_in} : 8'h00;
  assign hys_half = diff[7:1];
  // both caps apply at once: a wide span must not lift the ten percent cap
  assign hys_lim = (hys_half > `SOSEL_HYS_MAX) ? `SOSEL_HYS_MAX : hys_half;
  assign hys_c = (hys_in > hys_lim) ? hys_lim : hys_in;
  // upper kept at most 100, lower kept at most upper minus twice hysteresis
  assign up_c = (upper_in > `SOSEL_PCT_MAX) ? `SOSEL_PCT_MAX : upper_in;
  assign low_room = (up_c > {hys_c[5:0], 1'b0}) ?
                    {1'b0, up_c - {hys_c[5:0], 1'b0}} : 8'h00;
  assign low_c = ({1'b0, lower_in} > low_room) ? low_room[6:0] : lower_in;
  assign upper_eff = up_c;
  assign lower_eff = low_c;
  assign hys_eff = hys_c;
  // limits widen by the hysteresis once inside, so a noisy input won't chatter
  assign up_hi = hit_r ? {1'b0, up_c} + {1'b0, hys_c} :
                 {1'b0, up_c} - {1'b0, hys_c};
  assign low_lo = hit_r ? ((low_c > hys_c) ? {1'b0, low_c - hys_c} : 8'h00) :
                  {1'b0, low_c} + {1'b0, hys_c};
  // inside window means hit
  always @* begin
    hit_nxt = ({1'b0, ain} >= low_lo) && ({1'b0, ain} <= up_hi);
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end
endmodule // sosel_window

// >>> verilog/sosel_top.v
// status flag generator and output selector with apb registers
//
// Contract
// - ready flag high when commands are accepted
// - commands taken only while ready is high
// - forward flag only while driving forward
// - reverse flag only while driving reverse
// - listed trip errors raise major failure
// - window hit while input inside limits
// - hysteresis capped half span, ten percent
// - limits clamped to range and hysteresis
// - substitute level replaces input on hit
// - disconnect flag equals window hit
// - disconnect when input below upper limit
// - freq source flag: select 02, not second
// - run source flag: select 02, not second
// - second motor flag during second control
// - power-up ground check only when enabled
// - phase loss check 5 to 100 Hz
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "sosel_consts.vh"
module sosel_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire drive_ready,
  input wire drive_fwd,
  input wire drive_rev,
  input wire second_mode,
  input wire tripped,
  input wire [7:0] trip_code,
  input wire power_up,
  input wire [6:0] analog_inputs,
  input wire [15:0] out_freq,
  input wire run_cmd,
  output reg ready_to_accept,
  output reg forward_running,
  output reg reverse_running,
  output reg major_failure,
  output reg trip_indication,
  output reg window_hit,
  output reg disconnect_flag,
  output reg frequency_source_flag,
  output reg run_source_flag,
  output reg second_motor_active,
  output reg run_accepted,
  output reg gf_check_run,
  output reg pl_check_run,
  output reg [6:0] analog_applied,
  output reg terminal_out,
  output reg relay_out
);
  // ****************************************************
  // registers
  // ****************************************************
  // ctrl: [1:0] freq source, [3:2] run source, [4] gf en, [5] pl en
  // win: [6:0] upper, [14:8] lower, [22:16] hysteresis, stored raw, read back clamped
  // subst: [7] set means no substitute, [6:0] level in percent
  // sel: [7:0] terminal code, [15:8] relay code
  reg [31:0] ctrl_r;
  reg [31:0] win_r;
  reg [7:0] subst_r;
  reg [15:0] sel_r;
  reg [12:0] pin_s1_r;
  reg [12:0] pin_s2_r;
  reg [15:0] freq_s1_r;
  reg [15:0] freq_s2_r;
  reg [7:0] code_s1_r;
  reg [7:0] code_s2_r;
  reg [6:0] ain_s1_r;
  reg [6:0] ain_s2_r;
  wire [6:0] up_eff;
  wire [6:0] low_eff;
  wire [6:0] hys_eff;
  wire hit;
  wire wr_en;
  wire rd_en;
  wire [1:0] fsrc;
  wire [1:0] rsrc;
  // synced pin bits
  wire s_ready;
  wire s_fwd;
  wire s_rev;
  wire s_second;
  wire s_trip;
  wire s_pwr;
  wire s_run;
  reg [31:0] rd_nxt;
  reg err_nxt;

  // ****************************************************
  // selection function
  // ****************************************************
  // maps a selector code to the flag it names; unknown codes give 0
  // decoded once per output, so one chain serves terminal and relay alike
  function pick;
    input [7:0] code;
    input [8:0] flags;
    begin
      if (code == `SOSEL_CODE_DC) pick = flags[5];
      else if (code == `SOSEL_CODE_RDY) pick = flags[0];
      else if (code == `SOSEL_CODE_FWD) pick = flags[1];
      else if (code == `SOSEL_CODE_REV) pick = flags[2];
      else if (code == `SOSEL_CODE_MAJ) pick = flags[3];
      else if (code == `SOSEL_CODE_WIN) pick = flags[4];
      else if (code == `SOSEL_CODE_FSRC) pick = flags[6];
      else if (code == `SOSEL_CODE_RSRC) pick = flags[7];
      else if (code == `SOSEL_CODE_MOT2) pick = flags[8];
      else pick = 1'b0;
    end
  endfunction

  // ****************************************************
  // input synchronisers
  // ****************************************************
  // pins come from the drive core domain, two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 13'h0000;
      pin_s2_r <= 13'h0000;
      freq_s1_r <= 16'h0000;
      freq_s2_r <= 16'h0000;
      code_s1_r <= 8'h00;
      code_s2_r <= 8'h00;
      ain_s1_r <= 7'h00;
      ain_s2_r <= 7'h00;
    end else begin
      pin_s1_r <= {6'h00, run_cmd, power_up, tripped, second_mode,
                   drive_rev, drive_fwd, drive_ready};
      pin_s2_r <= pin_s1_r;
      freq_s1_r <= out_freq;
      freq_s2_r <= freq_s1_r;
      code_s1_r <= trip_code;
      code_s2_r <= code_s1_r;
      ain_s1_r <= analog_inputs;
      ain_s2_r <= ain_s1_r;
    end
  end
  assign s_ready = pin_s2_r[0];
  assign s_fwd = pin_s2_r[1];
  assign s_rev = pin_s2_r[2];
  assign s_second = pin_s2_r[3];
  assign s_trip = pin_s2_r[4];
  assign s_pwr = pin_s2_r[5];
  assign s_run = pin_s2_r[6];
  // source selects come from the control register, not from pins
  assign fsrc = ctrl_r[`SOSEL_CTRL_FSRC_LO+1:`SOSEL_CTRL_FSRC_LO];
  assign rsrc = ctrl_r[`SOSEL_CTRL_RSRC_LO+1:`SOSEL_CTRL_RSRC_LO];

  // ****************************************************
  // window comparator
  // ****************************************************
  // ain below upper limit with lower at 0 flags a disconnection
  sosel_window u_win (
    .pclk(pclk),
    .presetn(presetn),
    .ain(ain_s2_r),
    .upper_in(win_r[6:0]),
    .lower_in(win_r[14:8]),
    .hys_in(win_r[22:16]),
    .upper_eff(up_eff),
    .lower_eff(low_eff),
    .hys_eff(hys_eff),
    .hit_r(hit)
  );

  // ****************************************************
  // apb slave
  // ****************************************************
  // zero wait state: pready high in every access phase
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // read decode, unmapped addresses answer with pslverr
  always @* begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `SOSEL_OFF_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (paddr == `SOSEL_OFF_WIN) begin
      rd_nxt = {9'h000, hys_eff, 1'b0, low_eff, 1'b0, up_eff};
    end else if (paddr == `SOSEL_OFF_SUBST) begin
      rd_nxt = {24'h000000, subst_r};
    end else if (paddr == `SOSEL_OFF_SEL) begin
      rd_nxt = {16'h0000, sel_r};
    end else if (paddr == `SOSEL_OFF_STAT) begin
      rd_nxt = {18'h00000, relay_out, terminal_out, pl_check_run,
                gf_check_run, second_motor_active, run_source_flag,
                frequency_source_flag, disconnect_flag, window_hit,
                major_failure, reverse_running, forward_running,
                ready_to_accept, trip_indication};
    end else if (paddr == `SOSEL_OFF_AIN) begin
      rd_nxt = {25'h0000000, analog_applied};
    end else if (paddr == `SOSEL_OFF_FREQ) begin
      rd_nxt = {16'h0000, freq_s2_r};
    end else begin
      err_nxt = 1'b1;
    end
  end
  // register writes and read capture
  // read data taken in the setup cycle, so it stands through access
  // writes land only at the access edge, never in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SOSEL_RST_CTRL;
      win_r <= `SOSEL_RST_WIN;
      subst_r <= `SOSEL_RST_SUBST;
      sel_r <= `SOSEL_RST_SEL;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && err_nxt;
      if (rd_en) begin
        prdata <= rd_nxt;
      end
      if (wr_en) begin
        if (paddr == `SOSEL_OFF_CTRL) begin
          ctrl_r <= {26'h0000000, pwdata[5:0]};
        end else if (paddr == `SOSEL_OFF_WIN) begin
          win_r <= {9'h000, pwdata[22:16], 1'b0, pwdata[14:8], 1'b0,
                    pwdata[6:0]};
        end else if (paddr == `SOSEL_OFF_SUBST) begin
          subst_r <= pwdata[7:0];
        end else if (paddr == `SOSEL_OFF_SEL) begin
          sel_r <= pwdata[15:0];
        end
      end
    end
  end

  // ****************************************************
  // status flags and outputs
  // ****************************************************
  // all flags registered so every output leaves from a flop
  // a trip gates ready and both direction flags: a tripped drive
  // neither accepts commands nor drives the motor
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_to_accept <= 1'b0;
      forward_running <= 1'b0;
      reverse_running <= 1'b0;
      major_failure <= 1'b0;
      trip_indication <= 1'b0;
      window_hit <= 1'b0;
      disconnect_flag <= 1'b0;
      frequency_source_flag <= 1'b0;
      run_source_flag <= 1'b0;
      second_motor_active <= 1'b0;
      run_accepted <= 1'b0;
      gf_check_run <= 1'b0;
      pl_check_run <= 1'b0;
      analog_applied <= 7'h00;
      terminal_out <= 1'b0;
      relay_out <= 1'b0;
    end else begin
      ready_to_accept <= s_ready && !s_trip;
      run_accepted <= s_run && ready_to_accept;
      // both requests at once count as stopping
      forward_running <= s_fwd && !s_rev && !s_trip;
      reverse_running <= s_rev && !s_fwd && !s_trip;
      trip_indication <= s_trip;
      // trip code synced beside the trip pin, so both settle together
      // a code that changes mid-sync may show one stale cycle
      major_failure <= s_trip && (code_s2_r == `SOSEL_E_MEM ||
                       code_s2_r == `SOSEL_E_CUR ||
                       code_s2_r == `SOSEL_E_CPU ||
                       code_s2_r == `SOSEL_E_GND ||
                       code_s2_r == `SOSEL_E_THM);
      window_hit <= hit;
      disconnect_flag <= hit;
      // substitute has bit 7 set for "no"; values clamp to 100
      if (hit && !subst_r[7]) begin
        analog_applied <= (subst_r[6:0] > `SOSEL_PCT_MAX) ?
                          `SOSEL_PCT_MAX : subst_r[6:0];
      end else begin
        analog_applied <= ain_s2_r;
      end
      frequency_source_flag <= (fsrc == `SOSEL_SRC_02) && !s_second;
      run_source_flag <= (rsrc == `SOSEL_SRC_02) && !s_second;
      second_motor_active <= s_second;
      gf_check_run <= s_pwr && ctrl_r[`SOSEL_CTRL_GF_EN];
      pl_check_run <= ctrl_r[`SOSEL_CTRL_PL_EN] &&
                      freq_s2_r >= `SOSEL_PL_FMIN &&
                      freq_s2_r <= `SOSEL_PL_FMAX;
      // outputs select from the already registered flags, one cycle later
      terminal_out <= pick(sel_r[7:0], {second_motor_active, run_source_flag,
                      frequency_source_flag, disconnect_flag, window_hit,
                      major_failure, reverse_running, forward_running,
                      ready_to_accept});
      relay_out <= pick(sel_r[15:8], {second_motor_active, run_source_flag,
                   frequency_source_flag, disconnect_flag, window_hit,
                   major_failure, reverse_running, forward_running,
                   ready_to_accept});
    end
  end
endmodule // sosel_top

// >>> test/sosel_top_sva.sv
// assertions on the status output selector ports
`timescale 1ns/10ps
`include "sosel_consts.vh"
module sosel_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire drive_ready,
  input wire drive_fwd,
  input wire drive_rev,
  input wire second_mode,
  input wire tripped,
  input wire power_up,
  input wire [15:0] out_freq,
  input wire ready_to_accept,
  input wire forward_running,
  input wire reverse_running,
  input wire major_failure,
  input wire trip_indication,
  input wire window_hit,
  input wire disconnect_flag,
  input wire second_motor_active,
  input wire gf_check_run,
  input wire pl_check_run
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // settle count: $past reaches into reset for the first edges
  reg [2:0] up_r;
  always @(posedge pclk or negedge presetn)
    if (!presetn) up_r <= 3'h0;
    else if (up_r != 3'h4) up_r <= up_r + 3'h1;
  // ****************************************
  // flag relations, three edges from pin
  // ****************************************
  dc_same_a: assert property (disconnect_flag == window_hit)
    else $error("disconnect flag differs from window hit");
  dir_excl_a: assert property (!(forward_running && reverse_running))
    else $error("both direction flags high");
  fwd_follow_a: assert property (up_r == 3'h4 |->
    forward_running == ($past(drive_fwd, 3) && !$past(drive_rev, 3) &&
      !$past(tripped, 3)))
    else $error("forward flag wrong");
  rev_follow_a: assert property (up_r == 3'h4 |->
    reverse_running == ($past(drive_rev, 3) && !$past(drive_fwd, 3) &&
      !$past(tripped, 3)))
    else $error("reverse flag wrong");
  ready_follow_a: assert property (up_r == 3'h4 |->
    ready_to_accept == ($past(drive_ready, 3) && !$past(tripped, 3)))
    else $error("ready flag wrong");
  motor_follow_a: assert property (up_r == 3'h4 |->
    second_motor_active == $past(second_mode, 3))
    else $error("second motor flag wrong");
  major_trip_a: assert property (major_failure |-> trip_indication)
    else $error("major failure without trip");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  gf_cause_a: assert property (gf_check_run |-> $past(power_up, 3))
    else $error("ground check without power up");
  pl_range_a: assert property (pl_check_run |->
    $past(out_freq, 3) >= `SOSEL_PL_FMIN &&
    $past(out_freq, 3) <= `SOSEL_PL_FMAX)
    else $error("phase loss check out of band");
  cover property (window_hit);
  cover property (major_failure);
  cover property (pslverr);
  cover property (pl_check_run);
endmodule // sosel_chk

bind sosel_top sosel_chk i_chk (.*);

// >>> test/sosel_ctl.sv
// partner model: controller reading the outputs and issuing run
`timescale 1ns/10ps
module sosel_ctl (
  input wire pclk,
  input wire ready_to_accept,
  input wire terminal_out,
  input wire relay_out,
  input wire want_run,
  output logic run_cmd = 1'b0,
  output logic [1:0] seen = 2'h0
);
  // run offered only while ready, else the drive would drop it
  always @(posedge pclk) begin
    run_cmd <= want_run && ready_to_accept;
    seen <= {relay_out, terminal_out};
  end
endmodule // sosel_ctl

// >>> test/sosel_top_bench.sv
// testbench for the status output selector
`timescale 1ns/10ps
`include "sosel_consts.vh"
module sosel_top_bench;
  logic pclk, presetn, psel, penable, pwrite, want_run, h;
  logic drive_ready, drive_fwd, drive_rev, second_mode, tripped, power_up;
  logic [11:0] paddr;
  logic [31:0] pwdata, v;
  logic [7:0] trip_code;
  logic [6:0] analog_inputs;
  logic [15:0] out_freq;
  wire [31:0] prdata;
  wire [6:0] analog_applied;
  wire [1:0] seen;
  wire pready, pslverr, run_cmd, ready_to_accept, forward_running;
  wire reverse_running, major_failure, trip_indication, window_hit;
  wire disconnect_flag, frequency_source_flag, run_source_flag;
  wire second_motor_active, run_accepted, gf_check_run, pl_check_run;
  wire terminal_out, relay_out;
  logic [64:0] notes[$];
  logic [64:0] nt;
  int n_errors, samples_checked, k;
  logic [7:0] codes [8] = '{8'h08, 8'h0A, 8'h0B, 8'h0E, 8'h13, 8'h09,
    8'h00, 8'h14};
  logic [6:0] ains [5] = '{7'h32, 7'h55, 7'h19, 7'h28, 7'h05};
  logic [4:0] hits = 5'h09;
  logic [15:0] fqs [4] = '{16'h01F3, 16'h01F4, 16'h2710, 16'h2711};

  sosel_top i_sosel_top (.*);
  sosel_ctl i_sosel_ctl (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
    input logic [32:0] e);
    notes.push_back({m, e});
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  // read answers checked against the oldest note, error flag included
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      chk({pslverr, prdata & nt[64:33]}, nt[32:0]);
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, drive_ready, drive_fwd, drive_rev} = '0;
    {second_mode, tripped, power_up, want_run, presetn} = '0;
    {paddr, pwdata, trip_code, analog_inputs, out_freq} = '0;
    v = $urandom(32'h9F7A9108);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    want_run <= 1'b1;
    settle();
    rd(`SOSEL_OFF_CTRL, 32'h3F, 33'h0);
    rd(`SOSEL_OFF_WIN, 32'h7F7F7F, 33'h0);
    rd(`SOSEL_OFF_SUBST, 32'hFF, 33'h80);
    rd(`SOSEL_OFF_SEL, 32'hFFFF, 33'h0);
    rd(`SOSEL_OFF_STAT, 32'h3F9F, 33'h0);
    rd(12'h01C, 32'hFFFFFFFF, {1'b1, 32'h0});
    $display("test reset done");
    // random drive states and source selects against status bits
    for (k = 0; k < 12; k++) begin
      v = $urandom;
      if (k < 2) v[7:0] = {4'hA, 3'b110, k[0]};
      apb(`SOSEL_OFF_CTRL, 1'b1, {28'h0, v[7:4]});
      {drive_ready, drive_fwd, drive_rev, second_mode} <= v[3:0];
      settle();
      rd(`SOSEL_OFF_STAT, 32'h39F, {23'h0, v[0], v[7:6] == 2'h2 && !v[0],
        v[5:4] == 2'h2 && !v[0], 3'h0, v[1] && !v[2], v[2] && !v[1],
        v[3], 1'b0});
      chk({32'h0, run_accepted}, {32'h0, v[3]});
    end
    $display("test flags done");
    // trip codes: listed ones are major, ready drops
    drive_ready <= 1'b1;
    tripped <= 1'b1;
    for (k = 0; k < 8; k++) begin
      trip_code <= codes[k];
      settle();
      rd(`SOSEL_OFF_STAT, 32'h13, {28'h0, k < 5, 4'h1});
    end
    tripped <= 1'b0;
    $display("test trips done");
    // limits clamped, then a sweep through the window
    apb(`SOSEL_OFF_WIN, 1'b1, 32'h0019143C);
    rd(`SOSEL_OFF_WIN, 32'h7F7F7F, 33'h000A143C);
    apb(`SOSEL_OFF_WIN, 1'b1, 32'h000C1E78);
    rd(`SOSEL_OFF_WIN, 32'h7F7F7F, 33'h000A1E64);
    apb(`SOSEL_OFF_WIN, 1'b1, 32'h000A143C);
    apb(`SOSEL_OFF_SEL, 1'b1, 32'h361B);
    apb(`SOSEL_OFF_SUBST, 1'b1, 32'h2D);
    for (k = 0; k < 5; k++) begin
      analog_inputs <= ains[k];
      settle();
      h = hits[k];
      rd(`SOSEL_OFF_STAT, 32'h3060,
        {19'h0, h, h, 5'h0, h, h, 5'h0});
      rd(`SOSEL_OFF_AIN, 32'h7F, {26'h0, h ? 7'h2D : ains[k]});
      chk({31'h0, seen}, {31'h0, h, h});
    end
    analog_inputs <= 7'h28;
    apb(`SOSEL_OFF_SUBST, 1'b1, 32'h80);
    settle();
    rd(`SOSEL_OFF_AIN, 32'h7F, 33'h28);
    $display("test window done");
    // power-up ground check and phase loss band edges
    apb(`SOSEL_OFF_CTRL, 1'b1, 32'h30);
    power_up <= 1'b1;
    for (k = 0; k < 4; k++) begin
      out_freq <= fqs[k];
      settle();
      rd(`SOSEL_OFF_STAT, 32'hC00,
        {21'h0, k == 1 || k == 2, 1'b1, 10'h0});
    end
    apb(`SOSEL_OFF_CTRL, 1'b1, 32'h0);
    settle();
    rd(`SOSEL_OFF_STAT, 32'hC00, 33'h0);
    $display("test checks done");
    settle();
    end_sim();
  end
endmodule // sosel_top_bench
